/* adc_link_pkg.sv */
package adc_link_pkg;
   // converter result widths
   localparam int RESULT_BITS = 12;
   localparam int WIDE_RESULT_BITS = 14;
   localparam int SHORT_PAD_BITS = 2;
   // system clock
   localparam int CLK_PERIOD_NS = 8;
   // power-up hold time on convert_start_n
   localparam int POWERUP_TIME_US = 70;
   localparam int POWERUP_CYCLES = (POWERUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // conversion time of the on-chip oscillator
   localparam int CONV_TIME_NS = 640;
   localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // quiet_interval after a transfer before the next conversion
   localparam int QUIET_TIME_NS = 50;
   localparam int QUIET_CYCLES = (QUIET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // low pulse width of convert_start_n made by the host
   localparam int CNV_LOW_TIME_NS = 40;
   localparam int CNV_LOW_CYCLES = (CNV_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // serial clock made by the host
   localparam int SCLK_PERIOD_NS = 160;
   localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   // result buffer depth in the host
   localparam int FIFO_DEPTH = 8;
   // synchroniser reset values (idle levels of the lines)
   localparam logic [2:0] SYNC_HIGH = 3'h7;
   localparam logic [2:0] SYNC_LOW = 3'h0;

   typedef enum logic [1:0] {
      PWR_DOWN = 2'b00,
      PWR_WAKE = 2'b01,
      PWR_READY = 2'b10,
      PWR_CONV = 2'b11
   } pwr_state_t;

   typedef enum logic [2:0] {
      H_POWERUP = 3'b000,
      H_IDLE = 3'b001,
      H_CONV = 3'b010,
      H_WAIT = 3'b011,
      H_READ = 3'b100,
      H_QUIET = 3'b101,
      H_DOWN = 3'b110
   } host_state_t;
endpackage

/* adc_link_if.sv */
`timescale 1ns/10ps
interface adc_link_if;
   logic convert_start_n;
   logic chip_select_n;
   logic serial_clk;
   logic busy;
   logic serial_out_first;
   logic serial_out_first_oe;
   logic serial_out_second;
   logic serial_out_second_oe;

   modport device (
      input convert_start_n,
      input chip_select_n,
      input serial_clk,
      output busy,
      output serial_out_first,
      output serial_out_first_oe,
      output serial_out_second,
      output serial_out_second_oe
   );

   modport host (
      output convert_start_n,
      output chip_select_n,
      output serial_clk,
      input busy,
      input serial_out_first,
      input serial_out_first_oe,
      input serial_out_second,
      input serial_out_second_oe
   );
endinterface

/* result_fifo.sv */
`timescale 1ns/10ps
module result_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = adc_link_pkg::FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   import adc_link_pkg::*;
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic push;
   logic pop;

   // extra pointer bit tells full from empty
   assign in_ready_o = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
   assign out_valid_o = (wr_q != rd_q);
   assign out_data_o = mem_q[rd_q[AW-1:0]];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule

/* adc_device_end.sv */
// Function
// RULE_01: end-of-conversion convert level picks power mode
// RULE_02: convert falling starts; busy high during conversion
// RULE_03: host raises convert before busy falls
// RULE_04: convert low at busy fall: shut down
// RULE_05: results readable while shut down
// RULE_06: rising convert wakes; hold high before converting
// RULE_07: power-up hold high, first result valid
// RULE_08: host keeps convert low to reach shutdown
// RULE_09: both channels sampled together, internally timed
// RULE_10: select falling enables outputs, shows msb
// RULE_11: msb first, later bits on clock fall
// RULE_12: host takes first bit at first fall
// RULE_13: clock fall coinciding with select fall ignored
// RULE_14: host gives at least result-width clock pulses
// RULE_15: other result follows, short variant zero-padded
// RULE_16: outputs stay driven until select rises
// RULE_17: select rising three-states outputs at once
// RULE_18: host waits quiet interval before converting
// RULE_19: early select gives msb at busy fall
// RULE_20: select tied low: never three-state
// RULE_21: host reads one or both lines
// RULE_22: track from busy fall, hold at convert fall
// RULE_23: result width is a build parameter
`timescale 1ns/10ps
module adc_device_end #(
   parameter int RESULT_W = adc_link_pkg::RESULT_BITS,
   parameter int POWERUP_CYCLES = adc_link_pkg::POWERUP_CYCLES,
   parameter int CONV_CYCLES = adc_link_pkg::CONV_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   adc_link_if.device link,
   input wire logic [RESULT_W-1:0] sample_first_i,
   input wire logic [RESULT_W-1:0] sample_second_i,
   output logic [RESULT_W-1:0] result_first_o,
   output logic [RESULT_W-1:0] result_second_o,
   output logic shutdown_o,
   output logic tracking_o
);
   import adc_link_pkg::*;

   // zero padding and frame length follow from the width
   localparam int PAD = (RESULT_W == WIDE_RESULT_BITS) ? 0 : SHORT_PAD_BITS; // see RULE_23
   localparam int FRAME_W = 2 * RESULT_W + PAD; // see RULE_23
   localparam int CW = $clog2(POWERUP_CYCLES + CONV_CYCLES + 1);

   // pin synchronisers: [0] first stage, [1] second, [2] edge history
   logic [2:0] cnv_s_q;
   logic [2:0] cs_s_q;
   logic [2:0] sck_s_q;
   logic cnv_fall;
   logic cnv_rise;
   logic cs_fall;
   logic cs_low;
   logic sck_fall;

   pwr_state_t state_q;
   logic [CW-1:0] cnt_q;
   logic conv_done;
   logic busy_q;
   logic shut_q;
   logic track_q;
   logic [RESULT_W-1:0] held_first_q;
   logic [RESULT_W-1:0] held_second_q;
   logic [RESULT_W-1:0] res_first_q;
   logic [RESULT_W-1:0] res_second_q;
   logic [FRAME_W-1:0] frame_a_q;
   logic [FRAME_W-1:0] frame_b_q;
   logic oe_q;

   function automatic logic [FRAME_W-1:0] build_frame(
      input logic [RESULT_W-1:0] lead,
      input logic [RESULT_W-1:0] trail
   );
      logic [FRAME_W-1:0] f;
      f = (FRAME_W'(lead) << (RESULT_W + PAD)) | FRAME_W'(trail); // see RULE_15
      return f;
   endfunction

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnv_s_q <= SYNC_HIGH;
         cs_s_q <= SYNC_HIGH;
         sck_s_q <= SYNC_HIGH;
      end else begin
         cnv_s_q <= {cnv_s_q[1], cnv_s_q[0], link.convert_start_n};
         cs_s_q <= {cs_s_q[1], cs_s_q[0], link.chip_select_n};
         sck_s_q <= {sck_s_q[1], sck_s_q[0], link.serial_clk};
      end
   end

   assign cnv_fall = cnv_s_q[2] && !cnv_s_q[1];
   assign cnv_rise = !cnv_s_q[2] && cnv_s_q[1];
   assign cs_fall = cs_s_q[2] && !cs_s_q[1];
   assign cs_low = !cs_s_q[1];
   assign sck_fall = sck_s_q[2] && !sck_s_q[1];
   assign conv_done = (state_q == PWR_CONV) && (cnt_q == CW'(CONV_CYCLES - 1));

   // power and conversion sequencing; the oscillator is clk_i, never serial_clk
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= PWR_WAKE;
         cnt_q <= '0;
      end else begin
         unique case (state_q)
            PWR_DOWN: begin
               if (cnv_rise) begin // see RULE_06
                  state_q <= PWR_WAKE;
                  cnt_q <= '0;
               end
            end
            PWR_WAKE: begin
               // a low level restarts the power-up wait
               if (!cnv_s_q[1]) begin // see RULE_07
                  cnt_q <= '0;
               end else if (cnt_q == CW'(POWERUP_CYCLES - 1)) begin // see RULE_06
                  state_q <= PWR_READY;
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            PWR_READY: begin
               if (cnv_fall) begin // see RULE_02
                  state_q <= PWR_CONV;
                  cnt_q <= '0;
               end
            end
            PWR_CONV: begin
               if (conv_done) begin
                  // level at the end decides the mode
                  state_q <= cnv_s_q[1] ? PWR_READY : PWR_DOWN; // see RULE_01
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_q <= 1'b0;
         shut_q <= 1'b0;
      end else begin
         if (state_q == PWR_READY && cnv_fall) begin
            busy_q <= 1'b1; // see RULE_02
         end else if (conv_done) begin
            busy_q <= 1'b0; // see RULE_02
         end
         if (conv_done) begin
            shut_q <= !cnv_s_q[1]; // see RULE_04
         end else if (state_q == PWR_DOWN && cnv_rise) begin
            shut_q <= 1'b0;
         end
      end
   end

   // track and hold: both channels caught in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         track_q <= 1'b1;
         held_first_q <= '0;
         held_second_q <= '0;
      end else if (state_q == PWR_READY && cnv_fall) begin
         track_q <= 1'b0; // see RULE_22
         held_first_q <= sample_first_i; // see RULE_09
         held_second_q <= sample_second_i; // see RULE_09
      end else if (conv_done) begin
         track_q <= 1'b1; // see RULE_22
      end
   end

   // results survive shutdown; only a new conversion replaces them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         res_first_q <= '0;
         res_second_q <= '0;
      end else if (conv_done) begin
         res_first_q <= held_first_q; // see RULE_05
         res_second_q <= held_second_q; // see RULE_05
      end
   end

   // output enable follows select alone, no end-of-frame release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= cs_low; // see RULE_10 RULE_16 RULE_17 RULE_20
      end
   end

   // shifters: line a leads with the first result, line b with the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_a_q <= '0;
         frame_b_q <= '0;
      end else if (conv_done && cs_low) begin
         // select already low: msb appears with busy falling
         frame_a_q <= build_frame(held_first_q, held_second_q); // see RULE_19 RULE_20
         frame_b_q <= build_frame(held_second_q, held_first_q); // see RULE_19 RULE_20
      end else if (cs_fall) begin
         // a clock fall in this same cycle is dropped by this priority
         frame_a_q <= build_frame(res_first_q, res_second_q); // see RULE_10 RULE_13
         frame_b_q <= build_frame(res_second_q, res_first_q); // see RULE_10 RULE_13
      end else if (sck_fall && cs_low) begin
         // zeros fill in past the frame end, lines stay driven
         frame_a_q <= {frame_a_q[FRAME_W-2:0], 1'b0}; // see RULE_11 RULE_15 RULE_16
         frame_b_q <= {frame_b_q[FRAME_W-2:0], 1'b0}; // see RULE_11 RULE_15
      end
   end

   assign link.busy = busy_q;
   assign link.serial_out_first = frame_a_q[FRAME_W-1];
   assign link.serial_out_second = frame_b_q[FRAME_W-1];
   assign link.serial_out_first_oe = oe_q;
   assign link.serial_out_second_oe = oe_q;
   assign result_first_o = res_first_q;
   assign result_second_o = res_second_q;
   assign shutdown_o = shut_q;
   assign tracking_o = track_q;
endmodule

/* adc_host_end.sv */
`timescale 1ns/10ps
module adc_host_end #(
   parameter int RESULT_W = adc_link_pkg::RESULT_BITS,
   parameter int POWERUP_CYCLES = adc_link_pkg::POWERUP_CYCLES,
   parameter int DEPTH = adc_link_pkg::FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_i,
   adc_link_if.host link,
   input wire logic start_i,
   input wire logic stay_powered_i,
   output logic result_valid_o,
   input wire logic result_ready_i,
   output logic [2*RESULT_W-1:0] result_data_o
);
   import adc_link_pkg::*;
   localparam int CW = $clog2(POWERUP_CYCLES + 1);
   localparam int BW = $clog2(RESULT_W + 1);

   logic [2:0] busy_s_q;
   logic [1:0] da_s_q;
   logic [1:0] db_s_q;
   logic busy_fall;
   host_state_t state_q;
   logic [CW-1:0] cnt_q;
   logic [BW-1:0] bits_q;
   logic keep_q;
   logic cnv_n_q;
   logic cs_n_q;
   logic sck_q;
   logic [RESULT_W-1:0] sh_a_q;
   logic [RESULT_W-1:0] sh_b_q;
   logic push_q;
   logic fifo_ready;
   logic half_done;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_s_q <= SYNC_LOW;
         da_s_q <= 2'h0;
         db_s_q <= 2'h0;
      end else begin
         busy_s_q <= {busy_s_q[1], busy_s_q[0], link.busy};
         da_s_q <= {da_s_q[0], link.serial_out_first};
         db_s_q <= {db_s_q[0], link.serial_out_second};
      end
   end

   assign busy_fall = busy_s_q[2] && !busy_s_q[1];
   assign half_done = (cnt_q == CW'(SCLK_HALF_CYCLES - 1));

   // new conversions wait for room in the buffer: that is the back-pressure
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= H_POWERUP;
         cnt_q <= '0;
         bits_q <= '0;
         keep_q <= 1'b1;
         cnv_n_q <= 1'b1;
         cs_n_q <= 1'b1;
         sck_q <= 1'b1;
         push_q <= 1'b0;
         sh_a_q <= '0;
         sh_b_q <= '0;
      end else begin
         push_q <= 1'b0;
         unique case (state_q)
            H_POWERUP: begin
               cnv_n_q <= 1'b1;
               if (cnt_q == CW'(POWERUP_CYCLES - 1)) begin // see RULE_06 RULE_07
                  state_q <= H_IDLE;
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            H_IDLE: begin
               if (start_i && fifo_ready) begin
                  cnv_n_q <= 1'b0;
                  keep_q <= stay_powered_i;
                  cnt_q <= '0;
                  state_q <= H_CONV;
               end
            end
            H_CONV: begin
               if (cnt_q == CW'(CNV_LOW_CYCLES - 1)) begin
                  // raise now to stay powered, else hold low through busy
                  cnv_n_q <= keep_q; // see RULE_03 RULE_08
                  cnt_q <= '0;
                  state_q <= H_WAIT;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            H_WAIT: begin
               if (busy_fall) begin
                  cs_n_q <= 1'b0;
                  bits_q <= '0;
                  cnt_q <= '0;
                  state_q <= H_READ;
               end
            end
            H_READ: begin
               if (half_done) begin
                  cnt_q <= '0;
                  sck_q <= !sck_q;
                  if (sck_q) begin
                     // bit is taken as the clock falls, both lines in parallel
                     sh_a_q <= {sh_a_q[RESULT_W-2:0], da_s_q[1]}; // see RULE_12 RULE_21
                     sh_b_q <= {sh_b_q[RESULT_W-2:0], db_s_q[1]}; // see RULE_21
                     bits_q <= bits_q + 1'b1;
                  end else if (bits_q == BW'(RESULT_W)) begin // see RULE_14
                     sck_q <= 1'b1;
                     cs_n_q <= 1'b1; // see RULE_16
                     push_q <= 1'b1;
                     state_q <= H_QUIET;
                  end
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            H_QUIET: begin
               if (cnt_q == CW'(QUIET_CYCLES - 1)) begin // see RULE_18
                  cnt_q <= '0;
                  state_q <= keep_q ? H_IDLE : H_DOWN;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            H_DOWN: begin
               if (start_i && fifo_ready) begin
                  cnv_n_q <= 1'b1; // see RULE_06
                  cnt_q <= '0;
                  state_q <= H_POWERUP;
               end
            end
            default: begin
               state_q <= H_IDLE;
            end
         endcase
      end
   end

   result_fifo #(
      .WIDTH(2 * RESULT_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(push_q),
      .in_ready_o(fifo_ready),
      .in_data_i({sh_a_q, sh_b_q}),
      .out_valid_o(result_valid_o),
      .out_ready_i(result_ready_i),
      .out_data_o(result_data_o)
   );

   assign link.convert_start_n = cnv_n_q;
   assign link.chip_select_n = cs_n_q;
   assign link.serial_clk = sck_q;
endmodule

/* adc_link_assertions.sv */
`timescale 1ns/10ps
module adc_link_assertions #(
   parameter int RESULT_W = adc_link_pkg::RESULT_BITS,
   parameter int CONV_CYCLES = adc_link_pkg::CONV_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic convert_start_n,
   input wire logic chip_select_n,
   input wire logic serial_clk,
   input wire logic busy,
   input wire logic serial_out_first,
   input wire logic serial_out_first_oe,
   input wire logic serial_out_second,
   input wire logic serial_out_second_oe
);
   int busy_len_q;
   int falls_q;
   logic sclk_q;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   always_ff @(posedge clk_i) begin
      if (rst_i || !busy) begin
         busy_len_q <= 0;
      end else begin
         busy_len_q <= busy_len_q + 1;
      end
   end

   // pin level from the previous edge, so a fall is counted at the first edge that samples it, two edges before the device acts on it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sclk_q <= 1'h1;
      end else begin
         sclk_q <= serial_clk;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || chip_select_n) begin
         falls_q <= 0;
      end else if (sclk_q && !serial_clk) begin
         falls_q <= falls_q + 1;
      end
   end

   sequence cs_opens;
      ##[2:5] (serial_out_first_oe && serial_out_second_oe);
   endsequence

   sequence cs_closes;
      ##[1:4] (!serial_out_first_oe && !serial_out_second_oe);
   endsequence

   a_busy_start: assert property ($rose(busy) |-> !$past(convert_start_n, 3))
      else $error("busy rose without a convert request");
   a_busy_length: assert property ($fell(busy) |-> busy_len_q == CONV_CYCLES)
      else $error("busy length differs from conversion time");
   a_oe_open: assert property ($fell(chip_select_n) |-> cs_opens)
      else $error("outputs not driven after select fall");
   a_oe_close: assert property ($rose(chip_select_n) |-> cs_closes)
      else $error("outputs not released after select rise");
   a_oe_cause: assert property ($rose(serial_out_first_oe) |-> !$past(chip_select_n, 2))
      else $error("outputs driven without select");
   a_oe_pair: assert property (serial_out_first_oe == serial_out_second_oe)
      else $error("output enables differ");
   a_stay_driven: assert property ((!chip_select_n && serial_out_first_oe) |=> serial_out_first_oe)
      else $error("outputs released while selected");
   a_shift_edge: assert property (($changed(serial_out_first) || $changed(serial_out_second))
      && serial_out_first_oe && $past(serial_out_first_oe) |-> $fell(busy)
      || ($past(serial_clk, 4) && !$past(serial_clk, 3)) || ($past(serial_clk, 5) && !$past(serial_clk, 4))
      || ($past(serial_clk, 6) && !$past(serial_clk, 5)))
      else $error("data changed without a clock fall");
   a_clock_count: assert property ($rose(chip_select_n) |-> falls_q >= RESULT_W)
      else $error("too few clock falls in a read");
   a_quiet_gap: assert property ($rose(chip_select_n) |-> (!$fell(convert_start_n))[*7])
      else $error("conversion started inside the quiet interval");
endmodule

/* tb_dual_adc_conversion_readout.sv */
`timescale 1ns/10ps
module tb_dual_adc_conversion_readout;
   import adc_link_pkg::*;
   localparam int W = RESULT_BITS;
   // short power-up wait keeps the run brief; both ends get the same value
   localparam int PWR = 50;
   logic clk_i;
   logic rst_i;
   logic start_i;
   logic stay_powered_i;
   logic result_ready_i;
   logic rand_ready;
   logic [W-1:0] sample_first_i;
   logic [W-1:0] sample_second_i;
   logic [W-1:0] result_first_o;
   logic [W-1:0] result_second_o;
   logic shutdown_o;
   logic tracking_o;
   logic result_valid_o;
   logic [2*W-1:0] result_data_o;
   logic [31:0] lfsr;
   logic [2*W-1:0] res_q[$];
   logic [2*W:0] dev_q[$];
   logic [2*W:0] dev_e;
   int err_total;
   int tests_run;
   int conv_total;
   int pop_total;
   int base;

   adc_link_if i_adc_link_if ();

   adc_device_end #(.POWERUP_CYCLES(PWR)) i_adc_device_end (
      .clk_i(clk_i), .rst_i(rst_i), .link(i_adc_link_if.device),
      .sample_first_i(sample_first_i), .sample_second_i(sample_second_i),
      .result_first_o(result_first_o), .result_second_o(result_second_o),
      .shutdown_o(shutdown_o), .tracking_o(tracking_o)
   );

   adc_host_end #(.POWERUP_CYCLES(PWR)) i_adc_host_end (
      .clk_i(clk_i), .rst_i(rst_i), .link(i_adc_link_if.host),
      .start_i(start_i), .stay_powered_i(stay_powered_i), .result_valid_o(result_valid_o),
      .result_ready_i(result_ready_i), .result_data_o(result_data_o)
   );

   adc_link_assertions i_adc_link_assertions (
      .clk_i(clk_i), .rst_i(rst_i),
      .convert_start_n(i_adc_link_if.convert_start_n), .chip_select_n(i_adc_link_if.chip_select_n),
      .serial_clk(i_adc_link_if.serial_clk), .busy(i_adc_link_if.busy),
      .serial_out_first(i_adc_link_if.serial_out_first),
      .serial_out_first_oe(i_adc_link_if.serial_out_first_oe),
      .serial_out_second(i_adc_link_if.serial_out_second),
      .serial_out_second_oe(i_adc_link_if.serial_out_second_oe)
   );

   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic check_val(input logic [63:0] seen, input logic [63:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic run_phase(input logic stay, input int n, input string name);
      int i;
      base = conv_total + n;
      stay_powered_i = stay;
      start_i = 1'h1;
      i = 0;
      while (conv_total < base && i < 20000) begin
         @(negedge clk_i);
         i++;
      end
      check_val(64'(conv_total >= base), 64'h1, "phase conversions");
      start_i = 1'h0;
      repeat (600) @(negedge clk_i);
      $display("test %s done", name);
   endtask

   initial begin
      clk_i = 1'h0;
      forever #4 clk_i = ~clk_i;
   end

   // new analog values only while busy, after the sample is held
   always @(negedge clk_i) begin
      lfsr = lfsr_next(lfsr);
      if (rand_ready) begin
         result_ready_i = lfsr[0] | lfsr[1];
      end
      if (i_adc_link_if.busy === 1'h1) begin
         sample_first_i = lfsr[W-1:0];
         sample_second_i = lfsr[31:32-W];
      end
   end

   // the held sample is what the convert fall captures on both channels
   always @(negedge i_adc_link_if.convert_start_n) begin
      if (!rst_i) begin
         conv_total++;
         res_q.push_back({sample_first_i, sample_second_i});
         dev_q.push_back({stay_powered_i, sample_first_i, sample_second_i});
      end
   end

   // while busy the sample is held and the device is awake
   always @(posedge i_adc_link_if.busy) begin
      if (!rst_i) begin
         @(negedge clk_i);
         check_val(64'(tracking_o), 64'h0, "holding");
         check_val(64'(shutdown_o), 64'h0, "awake while busy");
      end
   end

   always @(negedge i_adc_link_if.busy) begin
      if (!rst_i) begin
         @(negedge clk_i);
         dev_e = dev_q.pop_front();
         check_val(64'(result_first_o), 64'(dev_e[2*W-1:W]), "first result");
         check_val(64'(result_second_o), 64'(dev_e[W-1:0]), "second result");
         check_val(64'(shutdown_o), 64'(!dev_e[2*W]), "power mode");
         check_val(64'(tracking_o), 64'h1, "tracking");
      end
   end

   always @(posedge clk_i) begin
      if (!rst_i && result_valid_o === 1'h1 && result_ready_i === 1'h1) begin
         pop_total++;
         check_val(64'(res_q.size() > 0), 64'h1, "unexpected result");
         if (res_q.size() > 0) begin
            check_val(64'(result_data_o), 64'(res_q.pop_front()), "read data");
         end
      end
   end

   initial begin
      repeat (40000) @(posedge clk_i);
      err_total++;
      $display("wrong value at %0t: watchdog expired", $time);
      stop_test();
   end

   initial begin
      err_total = 0;
      tests_run = 0;
      conv_total = 0;
      pop_total = 0;
      lfsr = 32'hf6534ef5;
      rst_i = 1'h1;
      start_i = 1'h0;
      stay_powered_i = 1'h1;
      result_ready_i = 1'h1;
      rand_ready = 1'h0;
      sample_first_i = '0;
      sample_second_i = '0;
      repeat (5) @(negedge clk_i);
      rst_i = 1'h0;
      run_phase(1'h1, 4, "normal back to back");
      run_phase(1'h0, 2, "shutdown and read");
      run_phase(1'h1, 2, "wake and convert");
      // fill the buffer with the reader stalled, then drain at random pace
      base = conv_total;
      result_ready_i = 1'h0;
      start_i = 1'h1;
      repeat (6000) @(negedge clk_i);
      check_val(64'(conv_total - base), 64'(FIFO_DEPTH), "stall count"); // buffer refuses when full
      check_val(64'(result_valid_o), 64'h1, "buffer valid"); // buffer holds its words
      start_i = 1'h0;
      rand_ready = 1'h1;
      repeat (4000) @(negedge clk_i);
      check_val(64'(pop_total), 64'(conv_total), "drained count");
      check_val(64'(res_q.size() + dev_q.size()), 64'h0, "leftover notes");
      $display("test buffer fill and drain done");
      stop_test();
   end
endmodule
